// ### hdl/vpd_pkg.sv
// Purpose: shared constants and types for the vector pattern driver
// Assumes: 40 MHz core clock, plain register port with 8-bit word address
// Notes: register numbers are word indices on the plain port
package vpd_pkg;

  // pattern store
  localparam int VEC_W = 40;
  localparam int OP_W = 3;
  localparam int DEPTH = 256;
  localparam int IDX_W = 8;
  localparam int RPT_W = 16;

  // per-vector statement codes
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_RPT_BEGIN = 3'h1;
  localparam logic [2:0] OP_RPT_END = 3'h2;
  localparam logic [2:0] OP_WAIT = 3'h3;
  localparam logic [2:0] OP_STOP = 3'h4;

  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h01;
  localparam logic [7:0] REG_START_INDEX = 8'h02;
  localparam logic [7:0] REG_REPEAT_COUNT = 8'h03;
  localparam logic [7:0] REG_LOAD_ADDR = 8'h04;
  localparam logic [7:0] REG_LOAD_LO = 8'h05;
  localparam logic [7:0] REG_LOAD_HI = 8'h06;
  localparam logic [7:0] REG_DIRECT_LO = 8'h07;
  localparam logic [7:0] REG_DIRECT_HI = 8'h08;
  localparam logic [7:0] REG_DIRECT_PIN = 8'h09;
  localparam logic [7:0] REG_STATUS = 8'h0a;

  // control bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_ARM = 1;
  localparam int CTRL_HALT = 2;
  localparam int CTRL_STEP = 3;

  // configuration fields
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_RATE_LSB = 2;
  localparam int CFG_DRIVE_FALL = 4;
  localparam int CFG_ARMED = 5;
  localparam int CFG_ENQ_LSB = 6;
  localparam int CFG_START_FALL = 8;
  localparam int CFG_STOP_FALL = 9;
  localparam int CFG_WAIT_FALL = 10;
  localparam int CFG_W = 11;
  localparam logic [10:0] CFG_RESET = 11'h000;

  // drive clock sources
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_STEP = 2'h2;

  // enable qualification
  localparam logic [1:0] ENQ_NONE = 2'h0;
  localparam logic [1:0] ENQ_HIGH = 2'h1;
  localparam logic [1:0] ENQ_LOW = 2'h2;

  // direct pin fields
  localparam int PIN_VAL = 8;

  // internal clock rates; code 0 is the reset rate
  localparam int CLK_HZ = 40_000_000;
  localparam int RATE0_HZ = 1_000_000;
  localparam int RATE1_HZ = 5_000_000;
  localparam int RATE2_HZ = 10_000_000;
  localparam int RATE3_HZ = 20_000_000;
  localparam int HALF_W = 5;
  localparam logic [4:0] HALF0 = 5'(CLK_HZ / (2 * RATE0_HZ));
  localparam logic [4:0] HALF1 = 5'(CLK_HZ / (2 * RATE1_HZ));
  localparam logic [4:0] HALF2 = 5'(CLK_HZ / (2 * RATE2_HZ));
  localparam logic [4:0] HALF3 = 5'(CLK_HZ / (2 * RATE3_HZ));

  // synchronised pin inputs
  localparam int SY_DCLK = 0;
  localparam int SY_START = 1;
  localparam int SY_STOP = 2;
  localparam int SY_EN = 3;
  localparam int SY_WAIT = 4;
  localparam int SY_FLOAT = 5;
  localparam int SY_W = 6;

  typedef enum logic [2:0] {
    VPD_IDLE, VPD_ARMED, VPD_WAIT_START, VPD_RUN, VPD_WAIT_HS
  } vpd_state_t;

endpackage

// ### hdl/vpd_vector_pattern_driver.sv
// Purpose: drives a stored vector pattern onto a 40-bit output toward a unit under test
// Assumes: pin inputs are asynchronous to clk and slower than half of clk
// Notes: one read or write strobe per cycle; read data valid the cycle after
`timescale 1ns/10ps

module vpd_vector_pattern_driver (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // unit under test pins
  input wire logic ext_drive_clock_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic enable_in,
  input wire logic wait_hs_in,
  input wire logic output_float_n,
  output logic int_clk_out,
  output logic [39:0] vec_out,
  output logic [39:0] vec_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and registers

  logic [42:0] pat_mem [0:255];
  logic pattern_valid;
  logic [10:0] cfg;
  logic [10:0] run_cfg;
  logic [7:0] start_index;
  logic [15:0] repeat_count;
  logic [7:0] load_addr;
  logic [31:0] load_lo;
  logic [31:0] direct_lo;
  vpd_pkg::vpd_state_t state;
  logic [7:0] idx;
  logic [7:0] rpt_begin;
  logic [15:0] loops_left;
  logic rpt_active;
  logic done;
  logic float_q;
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic [5:0] sy_prev;
  logic [4:0] half_cnt;
  logic [4:0] half_lim;

  wire wr_ctrl = reg_wr && reg_addr == vpd_pkg::REG_CTRL;
  wire go_cmd = wr_ctrl && reg_wdata[vpd_pkg::CTRL_GO];
  wire arm_cmd = wr_ctrl && reg_wdata[vpd_pkg::CTRL_ARM];
  wire halt_cmd = wr_ctrl && reg_wdata[vpd_pkg::CTRL_HALT];
  wire step_cmd = wr_ctrl && reg_wdata[vpd_pkg::CTRL_STEP];
  wire load_commit = reg_wr && reg_addr == vpd_pkg::REG_LOAD_HI;
  wire direct_word = reg_wr && reg_addr == vpd_pkg::REG_DIRECT_HI;
  wire direct_pin = reg_wr && reg_addr == vpd_pkg::REG_DIRECT_PIN;
  wire direct_any = direct_word || direct_pin;
  wire busy = state != vpd_pkg::VPD_IDLE;

  // configuration is copied into run_cfg at go, so polarities hold for a pattern
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= vpd_pkg::CFG_RESET;
      start_index <= 8'h00;
      repeat_count <= 16'h0000;
      load_lo <= 32'h0000_0000;
      direct_lo <= 32'h0000_0000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        vpd_pkg::REG_CONFIG: cfg <= reg_wdata[10:0];
        vpd_pkg::REG_START_INDEX: start_index <= reg_wdata[7:0];
        vpd_pkg::REG_REPEAT_COUNT: repeat_count <= reg_wdata[15:0];
        vpd_pkg::REG_LOAD_LO: load_lo <= reg_wdata;
        vpd_pkg::REG_DIRECT_LO: direct_lo <= reg_wdata;
        default: ;
      endcase
    end
  end

  // pattern load; a direct write takes the pattern's place
  always_ff @(posedge clk) begin
    if (load_commit) begin
      pat_mem[load_addr] <= {reg_wdata[10:8], reg_wdata[7:0], load_lo};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_addr <= 8'h00;
      pattern_valid <= 1'b0;
    end else if (reg_wr && reg_addr == vpd_pkg::REG_LOAD_ADDR) begin
      load_addr <= reg_wdata[7:0];
    end else if (load_commit) begin
      load_addr <= load_addr + 8'h01;
      pattern_valid <= 1'b1;
    end else if (direct_any) begin
      pattern_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sy1 <= 6'h00;
      sy2 <= 6'h00;
      sy_prev <= 6'h00;
    end else begin
      sy1 <= {output_float_n, wait_hs_in, enable_in, stop_in, start_in, ext_drive_clock_in};
      sy2 <= sy1;
      sy_prev <= sy2;
    end
  end

  wire [5:0] rise = sy2 & ~sy_prev;
  wire [5:0] fall = ~sy2 & sy_prev;
  wire [1:0] src = run_cfg[vpd_pkg::CFG_SRC_LSB +: 2];
  wire [1:0] enq = run_cfg[vpd_pkg::CFG_ENQ_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // internal clock: free-running at the last chosen rate

  always_comb begin
    unique case (cfg[vpd_pkg::CFG_RATE_LSB +: 2])
      2'h0: half_lim = vpd_pkg::HALF0;
      2'h1: half_lim = vpd_pkg::HALF1;
      2'h2: half_lim = vpd_pkg::HALF2;
      2'h3: half_lim = vpd_pkg::HALF3;
    endcase
  end

  // >= so a rate change to a shorter period cannot overrun the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_cnt <= 5'h00;
      int_clk_out <= 1'b0;
    end else if (half_cnt + 5'h01 >= half_lim) begin
      half_cnt <= 5'h00;
      int_clk_out <= ~int_clk_out;
    end else begin
      half_cnt <= half_cnt + 5'h01;
    end
  end

  wire int_tick = !int_clk_out && (half_cnt + 5'h01 >= half_lim);

  ////////////////////////////////////////////////////////////////////////////
  // drive clock selection and qualification

  logic src_edge;
  always_comb begin
    unique case (src)
      vpd_pkg::SRC_INT: src_edge = int_tick;
      vpd_pkg::SRC_EXT: src_edge = run_cfg[vpd_pkg::CFG_DRIVE_FALL] ?
                        fall[vpd_pkg::SY_DCLK] : rise[vpd_pkg::SY_DCLK];
      vpd_pkg::SRC_STEP: src_edge = step_cmd;
      default: src_edge = 1'b0;
    endcase
  end

  logic en_ok;
  always_comb begin
    unique case (enq)
      vpd_pkg::ENQ_HIGH: en_ok = sy2[vpd_pkg::SY_EN];
      vpd_pkg::ENQ_LOW: en_ok = !sy2[vpd_pkg::SY_EN];
      default: en_ok = 1'b1;
    endcase
  end

  wire qual_edge = src_edge && en_ok;
  wire start_edge = run_cfg[vpd_pkg::CFG_START_FALL] ?
                    fall[vpd_pkg::SY_START] : rise[vpd_pkg::SY_START];
  wire stop_edge_raw = run_cfg[vpd_pkg::CFG_STOP_FALL] ?
                       fall[vpd_pkg::SY_STOP] : rise[vpd_pkg::SY_STOP];
  wire stop_edge = stop_edge_raw &&
                   (src == vpd_pkg::SRC_INT || src == vpd_pkg::SRC_EXT);
  wire hs_edge = run_cfg[vpd_pkg::CFG_WAIT_FALL] ?
                 fall[vpd_pkg::SY_WAIT] : rise[vpd_pkg::SY_WAIT];

  wire [42:0] cur = pat_mem[idx];
  wire [2:0] cur_op = cur[42:40];
  wire present = state == vpd_pkg::VPD_RUN && qual_edge && !stop_edge;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= vpd_pkg::VPD_IDLE;
      run_cfg <= vpd_pkg::CFG_RESET;
    end else if (halt_cmd || direct_any || (busy && stop_edge)) begin
      state <= vpd_pkg::VPD_IDLE;
    end else begin
      unique case (state)
        vpd_pkg::VPD_IDLE: begin
          if (go_cmd && pattern_valid) begin
            run_cfg <= cfg;
            state <= cfg[vpd_pkg::CFG_ARMED] ? vpd_pkg::VPD_ARMED
                                             : vpd_pkg::VPD_WAIT_START;
          end
        end
        vpd_pkg::VPD_ARMED: begin
          if (arm_cmd) begin
            state <= vpd_pkg::VPD_WAIT_START;
          end
        end
        vpd_pkg::VPD_WAIT_START: begin
          if (start_edge) begin
            state <= vpd_pkg::VPD_RUN;
          end
        end
        vpd_pkg::VPD_RUN: begin
          if (present && cur_op == vpd_pkg::OP_STOP) begin
            state <= vpd_pkg::VPD_IDLE;
          end else if (present && cur_op == vpd_pkg::OP_WAIT) begin
            state <= vpd_pkg::VPD_WAIT_HS;
          end
        end
        vpd_pkg::VPD_WAIT_HS: begin
          if (hs_edge) begin
            state <= vpd_pkg::VPD_RUN;
          end
        end
      endcase
    end
  end

  // index and repeat bookkeeping; the block author keeps repeat blocks
  // at least two vectors long, so begin and end never share a slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx <= 8'h00;
      rpt_begin <= 8'h00;
      loops_left <= 16'h0000;
      rpt_active <= 1'b0;
    end else if (state == vpd_pkg::VPD_IDLE && go_cmd) begin
      idx <= start_index;
      rpt_active <= 1'b0;
    end else if (present) begin
      if (cur_op == vpd_pkg::OP_RPT_BEGIN) begin
        // later passes revisit the begin vector; reloading there would never end
        if (!rpt_active) begin
          rpt_begin <= idx;
          loops_left <= repeat_count;
          rpt_active <= 1'b1;
        end
        idx <= idx + 8'h01;
      end else if (cur_op == vpd_pkg::OP_RPT_END && loops_left != 16'h0000) begin
        loops_left <= loops_left - 16'h0001;
        idx <= rpt_begin;
      end else if (cur_op != vpd_pkg::OP_STOP) begin
        idx <= idx + 8'h01;
        if (cur_op == vpd_pkg::OP_RPT_END) begin
          rpt_active <= 1'b0;
        end
      end
    end
  end

  // done is set only by a stop statement, cleared by the next go
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else if (present && cur_op == vpd_pkg::OP_STOP && !direct_any && !halt_cmd) begin
      done <= 1'b1;
    end else if (go_cmd && state == vpd_pkg::VPD_IDLE) begin
      done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output data and float control

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_out <= 40'h00_0000_0000;
    end else if (direct_word) begin
      vec_out <= {reg_wdata[7:0], direct_lo};
    end else if (direct_pin) begin
      vec_out[reg_wdata[5:0]] <= reg_wdata[vpd_pkg::PIN_VAL];
    end else if (present) begin
      vec_out <= cur[39:0];
    end
  end

  // float is set asynchronously by the pin; it only clears on a clock, and
  // only when the synchronised pin is already high again, so a late
  // release leaves that vector internal
  always_ff @(posedge clk or posedge rst or negedge output_float_n) begin
    if (rst) begin
      float_q <= 1'b1;
    end else if (!output_float_n) begin
      float_q <= 1'b1;
    end else if ((direct_any || present) && sy2[vpd_pkg::SY_FLOAT]) begin
      float_q <= 1'b0;
    end
  end

  // the pin term keeps the float immediate, independent of clk
  assign vec_oe = {40{output_float_n && !float_q}};

  ////////////////////////////////////////////////////////////////////////////
  // register read

  wire [31:0] status_word = {16'h0000, idx, 3'h0, 3'(state), 
                             state != vpd_pkg::VPD_WAIT_HS, done};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        vpd_pkg::REG_CONFIG: reg_rdata <= {21'h000000, cfg};
        vpd_pkg::REG_START_INDEX: reg_rdata <= {24'h000000, start_index};
        vpd_pkg::REG_REPEAT_COUNT: reg_rdata <= {16'h0000, repeat_count};
        vpd_pkg::REG_LOAD_ADDR: reg_rdata <= {24'h000000, load_addr};
        vpd_pkg::REG_DIRECT_LO: reg_rdata <= vec_out[31:0];
        vpd_pkg::REG_DIRECT_HI: reg_rdata <= {24'h000000, vec_out[39:32]};
        vpd_pkg::REG_STATUS: reg_rdata <= status_word;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence seq_running_edge;
    state == vpd_pkg::VPD_RUN && qual_edge && !stop_edge && !direct_any && !halt_cmd;
  endsequence

  sequence seq_plain_vector;
    seq_running_edge ##0 cur_op == vpd_pkg::OP_NONE;
  endsequence

  AST_FLOAT_ASYNC: assert property (@(posedge clk) disable iff (rst)
    !output_float_n |-> vec_oe == 40'h00_0000_0000)
    else $error("outputs driven while float input low");

  AST_ADVANCE: assert property (@(posedge clk) disable iff (rst)
    seq_plain_vector |=> idx == $past(idx) + 8'h01 && vec_out == $past(cur[39:0]))
    else $error("index did not advance by one on qualified edge");

  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    state == vpd_pkg::VPD_RUN && !qual_edge && !direct_any |=> $stable(idx) && $stable(vec_out))
    else $error("position moved without qualified edge");

  AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (rst)
    state == vpd_pkg::VPD_WAIT_HS && !hs_edge && !direct_any && !stop_edge && !halt_cmd
    |=> state == vpd_pkg::VPD_WAIT_HS && $stable(vec_out))
    else $error("left handshake wait without edge");

  AST_WAIT_STATUS: assert property (@(posedge clk) disable iff (rst)
    state == vpd_pkg::VPD_WAIT_HS |-> status_word[1] == 1'b0)
    else $error("status shows not waiting during wait");

  AST_STOP_NOT_DONE: assert property (@(posedge clk) disable iff (rst)
    busy && stop_edge_raw && src == vpd_pkg::SRC_EXT && !done
    |=> state == vpd_pkg::VPD_IDLE && !done)
    else $error("stop edge did not end driving cleanly");

  AST_STOP_IGNORED: assert property (@(posedge clk) disable iff (rst)
    state == vpd_pkg::VPD_RUN && src == vpd_pkg::SRC_STEP && stop_edge_raw
    && !qual_edge && !direct_any && !halt_cmd |=> state == vpd_pkg::VPD_RUN)
    else $error("stop input acted in step mode");

  AST_DIRECT_ENDS: assert property (@(posedge clk) disable iff (rst)
    busy && direct_word ##1 1'b1 |-> state == vpd_pkg::VPD_IDLE && !pattern_valid)
    else $error("direct write did not end driving");

  AST_FAST_CLOCK: assert property (@(posedge clk) disable iff (rst)
    cfg[vpd_pkg::CFG_RATE_LSB +: 2] == 2'h3 [*3] |-> int_clk_out != $past(int_clk_out))
    else $error("internal clock not at 20 MHz");

  AST_ARM_GATE: assert property (@(posedge clk) disable iff (rst)
    state == vpd_pkg::VPD_ARMED && !arm_cmd |=> state != vpd_pkg::VPD_RUN
    && state != vpd_pkg::VPD_WAIT_START)
    else $error("armed mode started without arm command");

endmodule

// ### sim/vpd_uut_model.sv
// Purpose: unit under test board model that supplies drive clock, start, stop, enable, wait
// Assumes: bench calls the tasks below from its own sequence
// Notes: link clock stands still outside frames; pulses give one rising and one falling edge
`timescale 1ns/10ps

module vpd_uut_model (
  // pins toward the driver
  output logic ext_drive_clock_in,
  output logic start_in,
  output logic stop_in,
  output logic enable_in,
  output logic wait_hs_in,
  output logic output_float_n
);
  logic clk_on;

  initial begin
    ext_drive_clock_in = 1'b0;
    start_in = 1'b0;
    stop_in = 1'b0;
    enable_in = 1'b1;
    wait_hs_in = 1'b0;
    output_float_n = 1'b1;
    clk_on = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // 200 ns period keeps the link clock far below the 20 MHz ceiling
  always #100 if (clk_on) ext_drive_clock_in = ~ext_drive_clock_in;

  task automatic clk_run(input logic on);
    clk_on = on;
  endtask

  task automatic set_en(input logic v);
    enable_in = v;
  endtask

  task automatic set_float(input logic v);
    output_float_n = v;
  endtask

  // 0 start, 1 stop, 2 wait handshake; 300 ns wide so the 2-FF sampler sees both edges
  task automatic pulse(input int which);
    case (which)
      0: start_in = 1'b1;
      1: stop_in = 1'b1;
      default: wait_hs_in = 1'b1;
    endcase
    #300;
    case (which)
      0: start_in = 1'b0;
      1: stop_in = 1'b0;
      default: wait_hs_in = 1'b0;
    endcase
  endtask
endmodule

// ### sim/testbench.sv
// Purpose: self-checking bench for the vector pattern driver
// Assumes: register port with read data the cycle after the strobe
// Notes: vectors seen on vec_out are logged to a queue and checked per run
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ext_drive_clock_in, start_in, stop_in, enable_in, wait_hs_in, output_float_n;
  logic int_clk_out;
  logic [39:0] vec_out, vec_oe;
  logic [39:0] seen[$];
  logic [39:0] last_v = 40'h0;
  logic [31:0] d;
  int errors = 0;
  int compares = 0;
  int k, n;
  int rates[4] = '{1, 5, 10, 20};

  always #12.5 clk = ~clk;

  vpd_vector_pattern_driver u_vpd_vector_pattern_driver (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_drive_clock_in(ext_drive_clock_in), .start_in(start_in),
    .stop_in(stop_in), .enable_in(enable_in), .wait_hs_in(wait_hs_in),
    .output_float_n(output_float_n), .int_clk_out(int_clk_out), .vec_out(vec_out),
    .vec_oe(vec_oe));

  vpd_uut_model u_vpd_uut_model (.ext_drive_clock_in(ext_drive_clock_in),
    .start_in(start_in), .stop_in(stop_in), .enable_in(enable_in),
    .wait_hs_in(wait_hs_in), .output_float_n(output_float_n));

  ////////////////////////////////////////////////////////////////////////////////
  // log every new vector; all pattern words are distinct so no change is lost
  always @(posedge clk) begin
    #1;
    if (vec_out !== last_v) begin
      seen.push_back(vec_out);
      last_v = vec_out;
    end
  end

  task automatic close_out;
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    for (int i = 0; i < 400; i++) begin
      rd(vpd_pkg::REG_STATUS, v);
      if ((v & m) === e) return;
    end
    errors++;
    $display("[ERR] status exp %h got %h", e, v);
    close_out();
  endtask

  function automatic logic [39:0] pat(input int i);
    return {8'hc0 + 8'(i), 32'h1234_0000 + 32'(i)};
  endfunction

  // repeat block 1..4 holds two vectors between its markers
  task automatic ld(input int i, input logic [2:0] op);
    logic [39:0] p;
    p = pat(i);
    wr(vpd_pkg::REG_LOAD_ADDR, 32'(i));
    wr(vpd_pkg::REG_LOAD_LO, p[31:0]);
    wr(vpd_pkg::REG_LOAD_HI, {21'h0, op, p[39:32]});
  endtask

  // cycles between toggles of the internal clock, taken on the third toggle
  task automatic half(input int e);
    logic p;
    int c;
    for (int j = 0; j < 3; j++) begin
      p = int_clk_out;
      c = 0;
      while (int_clk_out === p && c < 100) begin
        @(posedge clk);
        #1 c++;
      end
    end
    `CHK("int_clk_half", e, c)
  endtask

  function automatic int cnt(input logic [39:0] v);
    int c = 0;
    foreach (seen[i]) if (seen[i] === v) c++;
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    errors++;
    $display("[ERR] run exp done got timeout");
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(vpd_pkg::REG_STATUS, d);
    `CHK("status_idle", 32'h2, d)
    `CHK("oe_after_reset", 40'h0, vec_oe)
    half(20);
    for (k = 0; k < 4; k++) begin
      wr(vpd_pkg::REG_CONFIG, 32'(k) << vpd_pkg::CFG_RATE_LSB);
      half(20 / rates[k]);
    end
    rd(8'h3f, d);
    `CHK("unmapped", 32'h0, d)
    // start 1, begin 1, end 4, wait 5, stop 7
    for (k = 0; k < 8; k++)
      ld(k, k == 1 ? vpd_pkg::OP_RPT_BEGIN : k == 4 ? vpd_pkg::OP_RPT_END :
        k == 5 ? vpd_pkg::OP_WAIT : k == 7 ? vpd_pkg::OP_STOP : vpd_pkg::OP_NONE);
    wr(vpd_pkg::REG_START_INDEX, 32'h1);
    wr(vpd_pkg::REG_REPEAT_COUNT, 32'h2);
    d = 32'(vpd_pkg::SRC_EXT) | (32'(vpd_pkg::ENQ_HIGH) << vpd_pkg::CFG_ENQ_LSB);
    wr(vpd_pkg::REG_CONFIG, d);
    rd(vpd_pkg::REG_CONFIG, d);
    `CHK("config_rb", 32'h41, d)
    // run 1: enable held low first, then a wait with handshake, then stop statement
    u_vpd_uut_model.set_en(1'b0);
    u_vpd_uut_model.clk_run(1'b1);
    seen.delete();
    wr(vpd_pkg::REG_CTRL, 32'h1 << vpd_pkg::CTRL_GO);
    u_vpd_uut_model.pulse(0);
    repeat (80) @(posedge clk);
    `CHK("held_no_enable", 0, seen.size())
    u_vpd_uut_model.set_en(1'b1);
    poll(32'h2, 32'h0);
    `CHK("first_vec", pat(1), seen[0])
    `CHK("second_vec", pat(2), seen[1])
    `CHK("end_passes", 3, cnt(pat(4)))
    n = seen.size();
    repeat (80) @(posedge clk);
    `CHK("wait_held", pat(5), vec_out)
    `CHK("wait_count", n, seen.size())
    `CHK("oe_driving", {40{1'b1}}, vec_oe)
    u_vpd_uut_model.pulse(2);
    poll(32'h1f, 32'h3);
    `CHK("resume_vec", pat(6), seen[n])
    `CHK("stop_vec", pat(7), vec_out)
    u_vpd_uut_model.clk_run(1'b0);
    // run 2: armed, falling drive edge, stop line ends it without done; pattern kept
    d = 32'(vpd_pkg::SRC_EXT) | (32'h1 << vpd_pkg::CFG_DRIVE_FALL) |
      (32'h1 << vpd_pkg::CFG_ARMED) | (32'h1 << vpd_pkg::CFG_STOP_FALL);
    wr(vpd_pkg::REG_CONFIG, d);
    seen.delete();
    wr(vpd_pkg::REG_CTRL, 32'h1 << vpd_pkg::CTRL_GO);
    u_vpd_uut_model.clk_run(1'b1);
    u_vpd_uut_model.pulse(0);
    repeat (80) @(posedge clk);
    rd(vpd_pkg::REG_STATUS, d);
    `CHK("armed_state", 32'h4, d & 32'h1c)
    `CHK("armed_quiet", 0, seen.size())
    wr(vpd_pkg::REG_CTRL, 32'h1 << vpd_pkg::CTRL_ARM);
    u_vpd_uut_model.pulse(0);
    poll(32'h1c, 32'hc);
    repeat (20) @(posedge clk);
    `CHK("kept_pattern", pat(1), seen[0])
    u_vpd_uut_model.pulse(1);
    poll(32'h1d, 32'h0);
    n = seen.size();
    repeat (40) @(posedge clk);
    `CHK("after_stop", n, seen.size())
    u_vpd_uut_model.clk_run(1'b0);
    // run 3: step mode ignores stop line; a direct write ends driving
    wr(vpd_pkg::REG_CONFIG, 32'(vpd_pkg::SRC_STEP));
    wr(vpd_pkg::REG_CTRL, 32'h1 << vpd_pkg::CTRL_GO);
    u_vpd_uut_model.pulse(0);
    poll(32'h1c, 32'hc);
    wr(vpd_pkg::REG_CTRL, 32'h1 << vpd_pkg::CTRL_STEP);
    u_vpd_uut_model.pulse(1);
    repeat (10) @(posedge clk);
    rd(vpd_pkg::REG_STATUS, d);
    `CHK("stop_ignored", 32'hc, d & 32'h1c)
    wr(vpd_pkg::REG_DIRECT_LO, 32'h89ab_cdef);
    wr(vpd_pkg::REG_DIRECT_HI, 32'h5a);
    poll(32'h1c, 32'h0);
    `CHK("direct_word", 40'h5a89abcdef, vec_out)
    u_vpd_uut_model.set_float(1'b0);
    #1 `CHK("float_now", 40'h0, vec_oe)
    u_vpd_uut_model.set_float(1'b1);
    repeat (10) @(posedge clk);
    `CHK("float_held", 40'h0, vec_oe)
    wr(vpd_pkg::REG_DIRECT_PIN, 32'h3);
    #1 `CHK("direct_pin", 40'h5a89abcde7, vec_out)
    `CHK("oe_back", {40{1'b1}}, vec_oe)
    close_out();
  end
endmodule
